// file: design/ltd_pkg.sv
// Package with register map, field layout, reset values and timing counts for the limit block.
package ltd_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] LTD_OFF_CTRL     = 8'h00;
  localparam logic [7:0] LTD_OFF_FAIL     = 8'h04;
  localparam logic [7:0] LTD_OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] LTD_OFF_IRQ_MASK = 8'h0C;
  localparam logic [7:0] LTD_OFF_INDIC    = 8'h10;
  localparam logic [7:0] LTD_OFF_PULSE_MS = 8'h14;
  localparam logic [7:0] LTD_OFF_BOUND    = 8'h20;
  localparam logic [7:0] LTD_OFF_BOUND_END = 8'h3C;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int LTD_CTRL_PAIR1_EN   = 0;
  localparam int LTD_CTRL_PAIR2_EN   = 1;
  localparam int LTD_CTRL_AUTOCLR1   = 2;
  localparam int LTD_CTRL_AUTOCLR2   = 3;
  localparam int LTD_CTRL_POL_LOW    = 4;
  localparam int LTD_CTRL_OUT_EN     = 5;
  localparam int LTD_CTRL_PULSE_EN   = 6;
  localparam int LTD_CTRL_MLATCH_EN  = 7;
  localparam int LTD_CTRL_W          = 8;
  localparam logic [7:0] LTD_CTRL_RESET = 8'h0C;

  // Indication register fields.
  localparam int LTD_IND_IN_RANGE = 0;
  localparam int LTD_IND_HIGH     = 1;
  localparam int LTD_IND_LOW      = 2;
  localparam int LTD_IND_PAIR_LSB = 4;
  localparam int LTD_IND_TWO_IN   = 6;

  // ----------------------------------------------------------------
  // Bounds: index 0 upper one, 1 lower one, 2 upper two, 3 lower two
  // ----------------------------------------------------------------
  localparam int LTD_BOUND_W = 33;
  localparam logic signed [32:0] LTD_BOUND_RESET [4] = '{33'sh000000001, -33'sh000000001,
                                                        33'sh000000002, -33'sh000000002};
  localparam logic [1:0] LTD_PAIR_NUM_ONE = 2'h1;
  localparam logic [1:0] LTD_PAIR_NUM_TWO = 2'h2;

  // ----------------------------------------------------------------
  // Pulse duration in milliseconds and timing
  // ----------------------------------------------------------------
  localparam int LTD_MS_W = 27;
  localparam logic [26:0] LTD_PULSE_MS_MIN   = 27'h0000001;
  localparam logic [26:0] LTD_PULSE_MS_MAX   = 27'h5F5E0FF;
  localparam logic [26:0] LTD_PULSE_MS_RESET = 27'h0000002;
  localparam int LTD_PRE_W        = 14;
  localparam int LTD_CLK_PERIOD_NS = 100;
  localparam int LTD_PULSE_UNIT_US = 1000;
  localparam int LTD_CYCLES_PER_MS = (LTD_PULSE_UNIT_US * 1000) / LTD_CLK_PERIOD_NS;

  localparam logic [1:0] LTD_RESP_OKAY   = 2'h0;
  localparam logic [1:0] LTD_RESP_SLVERR = 2'h2;

endpackage : ltd_pkg

// file: design/ltd_pulse_timer.sv
// Timed pulse generator for one limit output line.
module ltd_pulse_timer
  import ltd_pkg::*;
#(
  parameter int CYCLES_PER_MS = LTD_CYCLES_PER_MS
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                start,
  input  wire logic                cancel,
  input  wire logic [LTD_MS_W-1:0] dur_ms,
  output logic                     active
);

  localparam logic [LTD_PRE_W-1:0] PRE_LOAD = LTD_PRE_W'(CYCLES_PER_MS - 1);

  logic [LTD_PRE_W-1:0] pre_q;
  logic [LTD_MS_W-1:0]  ms_q;
  logic                 active_q;

  // The pulse lasts dur_ms times CYCLES_PER_MS cycles; a retrigger restarts it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_q <= 1'b0;
      pre_q    <= '0;
      ms_q     <= '0;
    end else if (cancel) begin
      active_q <= 1'b0;
    end else if (start) begin
      active_q <= 1'b1;
      pre_q    <= PRE_LOAD;
      ms_q     <= dur_ms - LTD_MS_W'(1);
    end else if (active_q) begin
      if (pre_q == '0) begin
        if (ms_q == '0) begin
          active_q <= 1'b0;
        end else begin
          ms_q  <= ms_q - LTD_MS_W'(1);
          pre_q <= PRE_LOAD;
        end
      end else begin
        pre_q <= pre_q - LTD_PRE_W'(1);
      end
    end
  end

  assign active = active_q;

  chk_pulse_ends_exact: assert property (@(posedge aclk) disable iff (!aresetn)
    (active_q && !cancel && !start && pre_q == '0 && ms_q == '0) |=> !active_q)
    else $error("pulse did not end on its final cycle");

  chk_pulse_start_load: assert property (@(posedge aclk) disable iff (!aresetn)
    (start && !cancel) |=> (active_q && pre_q == PRE_LOAD && ms_q == $past(dur_ms) - 27'h1))
    else $error("pulse did not load its duration");

endmodule : ltd_pulse_timer

// file: design/ltd_limit_unit.sv
// Limit test unit with two bound pairs, fail flags, limit output lines and an AXI4-Lite slave.
//
// Summary of operation
// - Hold signed upper and lower bounds for two pairs; resets one/minus one, two/minus two.
// - Each limit pair has its own independent enable.
// - Per-pair fail flag: 0 between bounds, 1 at or past either bound.
// - Fail flag omits which bound failed; high/low events are kept separately.
// - Without auto clear, a fail flag stays set until explicitly cleared.
// - With auto clear, the flag clears on entering idle; auto clear on at reset.
// - Output polarity active-high or active-low; active-high after reset.
// - Global output enable, off after reset; while off results do not drive outputs.
// - Pulse duration from one millisecond to maximum, default two milliseconds.
// - Pulse-mode enable, off after reset, picks steady level or timed pulse.
// - Master latch enable, off after reset, makes master line hold after failure.
// - Pair one off, pair two on: indications follow pair two, pair number 2.
// - Panel limit-disable turns off both pairs regardless of their own enables.
// - Active-low, pair one on: low failure drives line 1 low, high drives line 2.
// - Active-high line goes high on failure; active-low line goes low.
// - In pulse mode an in-limit reading ends any running pulse at once.
// - Master asserts on any of four failures; unless latched, releases when all pass.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
module ltd_limit_unit
  import ltd_pkg::*;
#(
  parameter int CYCLES_PER_MS = LTD_CYCLES_PER_MS
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic signed [32:0]     reading,
  input  wire logic                   reading_valid,
  input  wire logic                   idle_entry,
  input  wire logic                   panel_limit_disable,
  output logic [3:0]                  limit_out,
  output logic                        master_limit_out,
  output logic                        irq
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [LTD_CTRL_W-1:0]   ctrl_q;
  logic signed [32:0]      bound_q [4];
  logic [LTD_MS_W-1:0]     pulse_ms_q;
  logic [1:0]              fail_q;
  logic [3:0]              irq_stat_q;
  logic [3:0]              irq_mask_q;
  logic [3:0]              res_q;
  logic                    master_hold_q;
  logic [3:0]              limit_out_q;
  logic                    master_out_q;

  // Bus channel state.
  logic                    aw_have_q;
  logic                    w_have_q;
  logic [7:0]              awaddr_q;
  logic [31:0]             wdata_q;
  logic [3:0]              wstrb_q;
  logic                    bvalid_q;
  logic [1:0]              bresp_q;
  logic                    rvalid_q;
  logic [31:0]             rdata_q;
  logic [1:0]              rresp_q;

  function automatic logic [31:0] ltd_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction : ltd_merge

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  logic        do_write;
  logic [31:0] wr_ctrl;
  logic [31:0] wr_ms;
  logic [31:0] clr_bits;
  logic        wr_hit;
  logic [26:0] ms_clamped;

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign do_write      = aw_have_q && w_have_q && !bvalid_q;
  assign wr_ctrl       = ltd_merge({24'h000000, ctrl_q}, wdata_q, wstrb_q);
  assign wr_ms         = ltd_merge({5'h00, pulse_ms_q}, wdata_q, wstrb_q);
  assign clr_bits      = ltd_merge(32'h00000000, wdata_q, wstrb_q);
  assign wr_hit        = (awaddr_q[1:0] == 2'h0) && ((awaddr_q <= LTD_OFF_PULSE_MS) ||
                         (awaddr_q >= LTD_OFF_BOUND && awaddr_q <= LTD_OFF_BOUND_END));

  // Out-of-range durations are clamped rather than refused, so the line never pulses for zero.
  always_comb begin
    ms_clamped = wr_ms[26:0];
    if (wr_ms[31:27] != 5'h00 || wr_ms[26:0] > LTD_PULSE_MS_MAX) begin
      ms_clamped = LTD_PULSE_MS_MAX;
    end else if (wr_ms[26:0] < LTD_PULSE_MS_MIN) begin
      ms_clamped = LTD_PULSE_MS_MIN;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= LTD_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? LTD_RESP_OKAY : LTD_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q     <= LTD_CTRL_RESET;
      pulse_ms_q <= LTD_PULSE_MS_RESET;
      irq_mask_q <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        bound_q[i] <= LTD_BOUND_RESET[i];
      end
    end else if (do_write) begin
      if (awaddr_q == LTD_OFF_CTRL) begin
        ctrl_q <= wr_ctrl[LTD_CTRL_W-1:0];
      end
      if (awaddr_q == LTD_OFF_PULSE_MS) begin
        pulse_ms_q <= ms_clamped;
      end
      if (awaddr_q == LTD_OFF_IRQ_MASK) begin
        irq_mask_q <= clr_bits[3:0] | (irq_mask_q & ~{4{wstrb_q[0]}});
      end
      // Each bound is a low word and a sign word holding bit 32.
      for (int i = 0; i < 4; i++) begin
        if (awaddr_q == LTD_OFF_BOUND + 8'(8 * i)) begin
          bound_q[i][31:0] <= ltd_merge(bound_q[i][31:0], wdata_q, wstrb_q);
        end
        if (awaddr_q == LTD_OFF_BOUND + 8'(8 * i + 4) && wstrb_q[0]) begin
          bound_q[i][32] <= wdata_q[0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Limit tests
  // ----------------------------------------------------------------
  logic [1:0] pair_en;
  logic [3:0] test_now;
  logic [3:0] res_en;
  logic       fail_clr_wr;

  assign pair_en[0] = ctrl_q[LTD_CTRL_PAIR1_EN] && !panel_limit_disable;
  assign pair_en[1] = ctrl_q[LTD_CTRL_PAIR2_EN] && !panel_limit_disable;
  // Bit order: low one, high one, low two, high two, matching output lines one to four.
  assign test_now[0] = pair_en[0] && (reading <= bound_q[1]);
  assign test_now[1] = pair_en[0] && (reading >= bound_q[0]);
  assign test_now[2] = pair_en[1] && (reading <= bound_q[3]);
  assign test_now[3] = pair_en[1] && (reading >= bound_q[2]);
  assign res_en      = res_q & {pair_en[1], pair_en[1], pair_en[0], pair_en[0]};
  assign fail_clr_wr = do_write && (awaddr_q == LTD_OFF_FAIL);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_q <= 4'h0;
    end else if (reading_valid) begin
      res_q <= test_now;
    end
  end

  // Set wins over both the manual and the automatic clear, so no failure slips past.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fail_q <= 2'h0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (reading_valid && (test_now[2*p] || test_now[2*p+1])) begin
          fail_q[p] <= 1'b1;
        end else if (fail_clr_wr && clr_bits[p]) begin
          fail_q[p] <= 1'b0;
        end else if (idle_entry && ctrl_q[LTD_CTRL_AUTOCLR1 + p]) begin
          fail_q[p] <= 1'b0;
        end
      end
    end
  end

  // High-versus-low failure goes to the event record, which also feeds the interrupt.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= 4'h0;
    end else begin
      irq_stat_q <= (reading_valid ? test_now : 4'h0) |
                    (irq_stat_q & ~((do_write && awaddr_q == LTD_OFF_IRQ_STAT) ?
                                    clr_bits[3:0] : 4'h0));
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------------------------------
  // Indications
  // ----------------------------------------------------------------
  logic [1:0] shown;
  logic [1:0] pair_num;
  logic       in_range;

  always_comb begin
    shown    = 2'h0;
    pair_num = 2'h0;
    if (pair_en[0]) begin
      shown    = res_q[1:0];
      pair_num = LTD_PAIR_NUM_ONE;
    end else if (pair_en[1]) begin
      shown    = res_q[3:2];
      pair_num = LTD_PAIR_NUM_TWO;
    end
  end

  assign in_range = (pair_num != 2'h0) && (shown == 2'h0);

  // ----------------------------------------------------------------
  // Output lines
  // ----------------------------------------------------------------
  logic [3:0] pulse_active;
  logic [3:0] line_active;
  logic       pol_low;
  logic       in_limit_rd;

  assign pol_low     = ctrl_q[LTD_CTRL_POL_LOW];
  assign in_limit_rd = reading_valid && (test_now == 4'h0);

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_line
      ltd_pulse_timer #(
        .CYCLES_PER_MS(CYCLES_PER_MS)
      ) u_pulse (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (reading_valid && test_now[g]),
        .cancel  (in_limit_rd),
        .dur_ms  (pulse_ms_q),
        .active  (pulse_active[g])
      );
      assign line_active[g] = ctrl_q[LTD_CTRL_PULSE_EN] ? pulse_active[g] : res_en[g];
    end
  endgenerate

  // The master hold only ends on an idle entry or when the latch is switched off.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      master_hold_q <= 1'b0;
    end else if (!ctrl_q[LTD_CTRL_MLATCH_EN]) begin
      master_hold_q <= 1'b0;
    end else if (|res_en) begin
      master_hold_q <= 1'b1;
    end else if (idle_entry) begin
      master_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      limit_out_q  <= 4'h0;
      master_out_q <= 1'b0;
    end else begin
      limit_out_q  <= ({4{ctrl_q[LTD_CTRL_OUT_EN]}} & line_active) ^ {4{pol_low}};
      master_out_q <= (ctrl_q[LTD_CTRL_OUT_EN] && (|res_en || master_hold_q)) ^ pol_low;
    end
  end

  assign limit_out        = limit_out_q;
  assign master_limit_out = master_out_q;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic        rd_hit;

  always_comb begin
    rd_mux = 32'h00000000;
    rd_hit = (s_axi_araddr[1:0] == 2'h0);
    case (s_axi_araddr)
      LTD_OFF_CTRL:     rd_mux = {24'h000000, ctrl_q};
      LTD_OFF_FAIL:     rd_mux = {30'h00000000, fail_q};
      LTD_OFF_IRQ_STAT: rd_mux = {28'h0000000, irq_stat_q};
      LTD_OFF_IRQ_MASK: rd_mux = {28'h0000000, irq_mask_q};
      LTD_OFF_INDIC:    rd_mux = {25'h0000000, (pair_num == LTD_PAIR_NUM_TWO) && in_range,
                                  pair_num, 1'b0, shown[0], shown[1], in_range};
      LTD_OFF_PULSE_MS: rd_mux = {5'h00, pulse_ms_q};
      default: begin
        rd_hit = 1'b0;
        for (int i = 0; i < 4; i++) begin
          if (s_axi_araddr == LTD_OFF_BOUND + 8'(8 * i)) begin
            rd_mux = bound_q[i][31:0];
            rd_hit = 1'b1;
          end
          if (s_axi_araddr == LTD_OFF_BOUND + 8'(8 * i + 4)) begin
            rd_mux = {31'h00000000, bound_q[i][32]};
            rd_hit = 1'b1;
          end
        end
      end
    endcase
  end

  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= LTD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_hit ? LTD_RESP_OKAY : LTD_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_fail_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
    (reading_valid && pair_en[0] && (reading <= bound_q[1] || reading >= bound_q[0]))
    |=> fail_q[0])
    else $error("pair one fail flag not set");

  chk_fail_flag_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (fail_q[1] && !ctrl_q[LTD_CTRL_AUTOCLR2] && !(fail_clr_wr && clr_bits[1])) |=> fail_q[1])
    else $error("pair two fail flag dropped without clear");

  chk_auto_clear_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    (idle_entry && ctrl_q[LTD_CTRL_AUTOCLR1] && !reading_valid) |=> !fail_q[0])
    else $error("auto clear missed idle entry");

  chk_outputs_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_q[LTD_CTRL_OUT_EN] |=> (limit_out == {4{$past(pol_low)}}))
    else $error("disabled outputs were driven");

  chk_low_sense_line: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_q[LTD_CTRL_OUT_EN] && pol_low && !ctrl_q[LTD_CTRL_PULSE_EN] && res_en[0])
    |=> !limit_out[0])
    else $error("active-low line one not pulled low");

  chk_pulse_cancel: assert property (@(posedge aclk) disable iff (!aresetn)
    in_limit_rd |=> (pulse_active == 4'h0))
    else $error("pulse survived an in-limit reading");

  chk_master_any_fail: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_q[LTD_CTRL_OUT_EN] && (|res_en)) |=> (master_limit_out != $past(pol_low)))
    else $error("master line not asserted on failure");

  chk_master_release: assert property (@(posedge aclk) disable iff (!aresetn)
    (!ctrl_q[LTD_CTRL_MLATCH_EN] && res_en == 4'h0 && !master_hold_q) |=>
    (master_limit_out == $past(pol_low)))
    else $error("unlatched master line did not release");

  chk_pair_two_shown: assert property (@(posedge aclk) disable iff (!aresetn)
    (!pair_en[0] && pair_en[1]) |-> (pair_num == LTD_PAIR_NUM_TWO))
    else $error("pair two not reported");

  chk_panel_disable: assert property (@(posedge aclk) disable iff (!aresetn)
    (panel_limit_disable && reading_valid) |=> (res_q == 4'h0))
    else $error("panel disable ignored");

endmodule : ltd_limit_unit

// file: testbench/ltd_reading_src.sv
// Reading source model that feeds measured values to the limit block.
module ltd_reading_src (
  input  wire logic          aclk,
  output logic signed [32:0] reading,
  output logic               reading_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reading = '0;
    reading_valid = 1'b0;
  end
  // Between readings the bus shows the inverse value, so a stale sample cannot pass.
  task automatic send(input logic signed [32:0] v);
    @(posedge aclk);
    reading <= v;
    reading_valid <= 1'b1;
    @(posedge aclk);
    reading <= ~v;
    reading_valid <= 1'b0;
  endtask : send
endmodule : ltd_reading_src

// file: testbench/ltd_limit_unit_tb.sv
// Self-checking bench for the limit block: registers, limit lines and interrupt.
module ltd_limit_unit_tb
  import ltd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic               aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, idle, panel;
  logic [7:0]         awaddr, araddr;
  logic [31:0]        wdata, rdata, rd;
  logic [3:0]         limit_out, wstrb;
  logic [1:0]         bresp, rresp, rs, bs;
  logic               awready, wready, bvalid, arready, rvalid, master, irq, rv;
  logic signed [32:0] reading;
  int                 miscompares, checks, n;
  ltd_reading_src i_src (.aclk(aclk), .reading(reading), .reading_valid(rv));
  ltd_limit_unit #(.CYCLES_PER_MS(4)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .reading(reading), .reading_valid(rv), .idle_entry(idle), .panel_limit_disable(panel),
    .limit_out(limit_out), .master_limit_out(master), .irq(irq));
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // Readies are sampled at the falling edge, where they are settled.
  task automatic wrs(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic pa, pw;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(negedge aclk);
      pa = pa && !awready;
      pw = pw && !wready;
      @(posedge aclk);
      if (!pa) awvalid <= 1'b0;
      if (!pw) wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!bvalid);
    bs = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wrs
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wrs(a, d, 4'hF);
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    rd = rdata;
    rs = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rdr
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rdr(a);
    cmp(rd & m, e);
  endtask : rchk
  task automatic settle;
    repeat (3) @(negedge aclk);
  endtask : settle
  task automatic pulse_idle;
    @(posedge aclk);
    idle <= 1'b1;
    @(posedge aclk);
    idle <= 1'b0;
  endtask : pulse_idle
  task automatic wrap_up;
    $display("miscompares %0d checks %0d", miscompares, checks);
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    wrap_up();
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, idle, panel} = '0;
    {awaddr, araddr, wdata, wstrb, miscompares, checks} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(LTD_OFF_CTRL, 32'hFF, 32'h0C);
    rchk(LTD_OFF_PULSE_MS, 32'hFFFFFFFF, 32'h2);
    rchk(LTD_OFF_BOUND, 32'hFFFFFFFF, 32'h1);
    rchk(LTD_OFF_BOUND + 8'h0C, 32'h1, 32'h1);
    rchk(LTD_OFF_BOUND + 8'h18, 32'hFFFFFFFF, 32'hFFFFFFFE);
    rdr(8'h18);
    cmp(32'(rs), 32'(LTD_RESP_SLVERR));
    cmp(32'(limit_out), 32'h0);
    wr(LTD_OFF_PULSE_MS, 32'h0);
    rchk(LTD_OFF_PULSE_MS, 32'hFFFFFFFF, 32'h1);
    wr(LTD_OFF_CTRL, 32'h0D);
    i_src.send(-33'sd1);
    settle();
    cmp(32'(limit_out), 32'h0);
    rchk(LTD_OFF_FAIL, 32'h3, 32'h1);
    pulse_idle();
    rchk(LTD_OFF_FAIL, 32'h3, 32'h0);
    wr(LTD_OFF_CTRL, 32'h31);
    i_src.send(-33'sd1);
    settle();
    cmp(32'(limit_out), 32'hE);
    cmp(32'(master), 32'h0);
    rchk(LTD_OFF_IRQ_STAT, 32'hF, 32'h1);
    wr(LTD_OFF_IRQ_MASK, 32'h1);
    cmp(32'(irq), 32'h1);
    i_src.send(33'sd0);
    settle();
    cmp(32'(master), 32'h1);
    rchk(LTD_OFF_FAIL, 32'h3, 32'h1);
    wr(LTD_OFF_FAIL, 32'h1);
    rchk(LTD_OFF_FAIL, 32'h3, 32'h0);
    wr(LTD_OFF_IRQ_STAT, 32'h1);
    cmp(32'(irq), 32'h0);
    panel <= 1'b1;
    i_src.send(-33'sd1);
    settle();
    cmp(32'(limit_out), 32'hF);
    @(posedge aclk);
    panel <= 1'b0;
    wrs(LTD_OFF_BOUND, 32'hAABBCCDD, 4'h1);
    cmp(32'(bs), 32'(LTD_RESP_OKAY));
    rchk(LTD_OFF_BOUND, 32'hFFFFFFFF, 32'hDD);
    wr(8'h18, 32'h0);
    cmp(32'(bs), 32'(LTD_RESP_SLVERR));
    wr(LTD_OFF_CTRL, 32'hE2);
    i_src.send(33'sd2);
    n = 0;
    repeat (20) begin
      @(negedge aclk);
      n += int'(limit_out[3]);
    end
    cmp(32'(n), 32'h4);
    rchk(LTD_OFF_INDIC, 32'h77, 32'h22);
    i_src.send(33'sd0);
    settle();
    cmp(32'(master), 32'h1);
    rchk(LTD_OFF_INDIC, 32'h40, 32'h40);
    pulse_idle();
    settle();
    cmp(32'(master), 32'h0);
    wr(LTD_OFF_PULSE_MS, 32'h5);
    i_src.send(33'sd2);
    settle();
    cmp(32'(limit_out[3]), 32'h1);
    i_src.send(33'sd0);
    settle();
    cmp(32'(limit_out[3]), 32'h0);
    wrap_up();
  end
endmodule : ltd_limit_unit_tb
